// file: design/ptdcc_top.sv
// Function
// - Debug halt with run bit clear stops the timer and ignores events.
// - Run bit set keeps the timer running while the CPU is halted.
// - Fault select set: debug halt with run bit clear raises fault and sets both trigger flags.
// - Fault select clear: debug halt gives no fault indication.
// - Trigger A or software capture A records the counter for snapshot A.
// - Trigger B or software capture B records the counter for snapshot B.
// - Captures go to a buffer; snapshots load it on an update condition.
// - Loaded snapshot blocks new updates until its high byte is read.
// - Three thresholds compared with the counter each running cycle; set A and clear A drive waveform A.
// - Thresholds are 12-bit read/write, low/high byte pair, reset zero.
// - Snapshots are read-only 12-bit, upper bits read zero, reset zero.
module ptdcc_top import ptdcc_pkg::*; #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Timer core
  input wire logic [CNT_W-1:0] count_value,
  input wire logic update_cond,
  input wire logic debug_halted,
  input wire logic trig_a_event,
  input wire logic trig_b_event,
  output logic timer_run,
  output logic fault_out,
  output logic trig_flag_a,
  output logic trig_flag_b,
  // Comparators and waveform
  output logic match_set_a,
  output logic match_clr_a,
  output logic match_set_b,
  output logic wave_a
);

  typedef struct packed {
    logic [7:0] wr_idx;
    logic wr_pend;
    logic [7:0] rdata;
    logic run_halted;
    logic fault_sel;
    logic [CNT_W-1:0] set_a;
    logic [CNT_W-1:0] clr_a;
    logic [CNT_W-1:0] set_b;
    logic flag_a;
    logic flag_b;
    logic fault;
    logic m_set_a;
    logic m_clr_a;
    logic m_set_b;
    logic wave_a;
  } ptdcc_regs_t;

  ptdcc_regs_t r;
  ptdcc_regs_t next_r;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  logic addr_ok;
  logic rd_req;
  logic wr_req;
  logic [7:0] idx;
  logic [7:0] rd_byte;
  logic halt;
  logic running;
  logic rel_a;
  logic rel_b;
  logic sw_cap_a;
  logic sw_cap_b;
  logic cap_a;
  logic cap_b;
  logic wr_cmd;
  logic [CNT_W-1:0] snap_a;
  logic [CNT_W-1:0] snap_b;
  logic lock_a;
  logic lock_b;

  // Only word-aligned addresses inside the first 1 KiB are mapped
  assign addr_ok = hsel & htrans[1] & hready & (haddr[1:0] == 2'h0)
                   & (haddr[31:10] == 22'h000000);
  assign idx = haddr[9:2];
  assign rd_req = addr_ok & ~hwrite;
  assign wr_req = addr_ok & hwrite;

  // ------------------------------------------------------------
  // Debug halt
  // ------------------------------------------------------------
  // halt qualifier
  assign halt = debug_halted & ~r.run_halted;
  assign running = ~halt;
  assign timer_run = running;

  // ------------------------------------------------------------
  // Capture paths
  // ------------------------------------------------------------
  assign wr_cmd = r.wr_pend & (r.wr_idx == IDX_CAP_CMD);
  assign sw_cap_a = wr_cmd & hwdata[CMD_CAP_A_BIT];
  assign sw_cap_b = wr_cmd & hwdata[CMD_CAP_B_BIT];
  assign cap_a = (trig_a_event & running) | sw_cap_a;
  assign cap_b = (trig_b_event & running) | sw_cap_b;
  assign rel_a = rd_req & (idx == IDX_SNAP_A_HI);
  assign rel_b = rd_req & (idx == IDX_SNAP_B_HI);

  ptdcc_snapshot #(.CNT_W(CNT_W)) u_snap_a (
    .clk(clk),
    .reset_n(reset_n),
    .count_value(count_value),
    .capture(cap_a),
    .update_cond(update_cond),
    .release_lock(rel_a),
    .snap_value(snap_a),
    .snap_locked(lock_a)
  );

  ptdcc_snapshot #(.CNT_W(CNT_W)) u_snap_b (
    .clk(clk),
    .reset_n(reset_n),
    .count_value(count_value),
    .capture(cap_b),
    .update_cond(update_cond),
    .release_lock(rel_b),
    .snap_value(snap_b),
    .snap_locked(lock_b)
  );

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  function automatic logic [7:0] byte_of(logic [CNT_W-1:0] v, logic hi);
    logic [15:0] w;
    w = VALUE_RESET | 16'(v);
    return hi ? w[15:8] : w[7:0];
  endfunction

  always_comb begin
    case (idx)
      IDX_DEBUG: begin
        rd_byte = DEBUG_RESET;
        rd_byte[DBG_RUN_BIT] = r.run_halted;
        rd_byte[DBG_FAULT_BIT] = r.fault_sel;
      end
      IDX_SNAP_A_LO: rd_byte = byte_of(snap_a, 1'b0);
      IDX_SNAP_A_HI: rd_byte = byte_of(snap_a, 1'b1);
      IDX_SNAP_B_LO: rd_byte = byte_of(snap_b, 1'b0);
      IDX_SNAP_B_HI: rd_byte = byte_of(snap_b, 1'b1);
      IDX_SET_A_LO: rd_byte = byte_of(r.set_a, 1'b0);
      IDX_SET_A_HI: rd_byte = byte_of(r.set_a, 1'b1);
      IDX_CLR_A_LO: rd_byte = byte_of(r.clr_a, 1'b0);
      IDX_CLR_A_HI: rd_byte = byte_of(r.clr_a, 1'b1);
      IDX_SET_B_LO: rd_byte = byte_of(r.set_b, 1'b0);
      IDX_SET_B_HI: rd_byte = byte_of(r.set_b, 1'b1);
      IDX_STATUS: begin
        rd_byte = 8'h00;
        rd_byte[ST_HALT_BIT] = halt;
        rd_byte[ST_FAULT_BIT] = r.fault;
        rd_byte[ST_LOCK_A_BIT] = lock_a;
        rd_byte[ST_LOCK_B_BIT] = lock_b;
        rd_byte[ST_FLAG_A_BIT] = r.flag_a;
        rd_byte[ST_FLAG_B_BIT] = r.flag_b;
      end
      // Unmapped and write-only locations read as zero
      default: rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    if (rd_req) begin
      next_r.rdata = rd_byte;
    end
    next_r.wr_pend = wr_req;
    if (wr_req) begin
      next_r.wr_idx = idx;
    end
    if (r.wr_pend) begin
      case (r.wr_idx)
        IDX_DEBUG: begin
          next_r.run_halted = hwdata[DBG_RUN_BIT];
          next_r.fault_sel = hwdata[DBG_FAULT_BIT];
        end
        IDX_SET_A_LO: next_r.set_a[7:0] = hwdata[7:0];
        IDX_SET_A_HI: next_r.set_a[CNT_W-1:8] = hwdata[CNT_W-9:0];
        IDX_CLR_A_LO: next_r.clr_a[7:0] = hwdata[7:0];
        IDX_CLR_A_HI: next_r.clr_a[CNT_W-1:8] = hwdata[CNT_W-9:0];
        IDX_SET_B_LO: next_r.set_b[7:0] = hwdata[7:0];
        IDX_SET_B_HI: next_r.set_b[CNT_W-1:8] = hwdata[CNT_W-9:0];
        IDX_STATUS: begin
          // Write one to clear; a fresh set below still wins
          if (hwdata[ST_FLAG_A_BIT]) begin
            next_r.flag_a = 1'b0;
          end
          if (hwdata[ST_FLAG_B_BIT]) begin
            next_r.flag_b = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    next_r.fault = halt & r.fault_sel;
    if (halt & r.fault_sel) begin
      next_r.flag_a = 1'b1;
      next_r.flag_b = 1'b1;
    end
    next_r.m_set_a = running & (count_value == r.set_a);
    next_r.m_clr_a = running & (count_value == r.clr_a);
    next_r.m_set_b = running & (count_value == r.set_b);
    // Set has priority when both thresholds are equal
    if (r.m_set_a) begin
      next_r.wave_a = 1'b1;
    end else if (r.m_clr_a) begin
      next_r.wave_a = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign hrdata = 32'(r.rdata);
  // Zero-wait slave: every transfer completes with OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign fault_out = r.fault;
  assign trig_flag_a = r.flag_a;
  assign trig_flag_b = r.flag_b;
  assign match_set_a = r.m_set_a;
  assign match_clr_a = r.m_clr_a;
  assign match_set_b = r.m_set_b;
  assign wave_a = r.wave_a;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_HALT_STOPS: assert property (
    debug_halted && !r.run_halted |-> !timer_run
      ##1 !match_set_a && !match_clr_a && !match_set_b)
    else $error("timer kept running in debug halt");

  AST_RUN_WHILE_HALTED_RUNS: assert property (
    r.run_halted |-> timer_run
      ##1 match_set_a == $past(count_value == r.set_a))
    else $error("timer stopped although run bit set");

  AST_HALT_FAULT: assert property (
    debug_halted && !r.run_halted && r.fault_sel
      |=> fault_out && trig_flag_a && trig_flag_b)
    else $error("debug halt did not raise fault and flags");

  AST_NO_FAULT: assert property (
    !r.fault_sel |=> !fault_out)
    else $error("fault raised with fault select clear");

  AST_CMP_MATCH: assert property (
    timer_run && count_value == r.clr_a |=> match_clr_a)
    else $error("clear A comparator missed a match");

  AST_WAVE_SET: assert property (
    match_set_a |=> wave_a)
    else $error("waveform A not set by set match");

  AST_SET_B_WRITE: assert property (
    r.wr_pend && r.wr_idx == IDX_SET_B_HI
      |=> r.set_b[CNT_W-1:8] == $past(hwdata[CNT_W-9:0]))
    else $error("set B high byte write lost");

  AST_SNAP_HI_ZERO: assert property (
    rd_req && idx == IDX_SNAP_A_HI |=> hrdata[31:CNT_W-8] == '0)
    else $error("snapshot high byte shows unused bits");

  AST_ZERO_WAIT: assert property (
    hreadyout && !hresp)
    else $error("slave did not answer OKAY with zero wait");

  COV_HALT_FAULT: cover property (
    debug_halted && !r.run_halted && r.fault_sel ##1 fault_out);
  COV_SNAP_RELEASE: cover property (lock_a ##1 rel_a ##1 !lock_a);
  COV_WAVE_CYCLE: cover property (wave_a ##[1:50] !wave_a);
  COV_SW_CAPTURE: cover property (sw_cap_b ##[1:20] lock_b);

endmodule // ptdcc_top

// file: design/ptdcc_pkg.sv
package ptdcc_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [7:0] IDX_DEBUG = 8'h1E;
  localparam logic [7:0] IDX_SNAP_A_LO = 8'h22;
  localparam logic [7:0] IDX_SNAP_A_HI = 8'h23;
  localparam logic [7:0] IDX_SNAP_B_LO = 8'h24;
  localparam logic [7:0] IDX_SNAP_B_HI = 8'h25;
  localparam logic [7:0] IDX_SET_A_LO = 8'h28;
  localparam logic [7:0] IDX_SET_A_HI = 8'h29;
  localparam logic [7:0] IDX_CLR_A_LO = 8'h2A;
  localparam logic [7:0] IDX_CLR_A_HI = 8'h2B;
  localparam logic [7:0] IDX_SET_B_LO = 8'h2C;
  localparam logic [7:0] IDX_SET_B_HI = 8'h2D;
  localparam logic [7:0] IDX_CAP_CMD = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int DBG_RUN_BIT = 0;
  localparam int DBG_FAULT_BIT = 2;
  localparam int CMD_CAP_A_BIT = 0;
  localparam int CMD_CAP_B_BIT = 1;
  localparam int ST_HALT_BIT = 0;
  localparam int ST_FAULT_BIT = 1;
  localparam int ST_LOCK_A_BIT = 2;
  localparam int ST_LOCK_B_BIT = 3;
  localparam int ST_FLAG_A_BIT = 4;
  localparam int ST_FLAG_B_BIT = 5;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] DEBUG_RESET = 8'h00;
  localparam logic [15:0] VALUE_RESET = 16'h0000;

endpackage

// file: design/ptdcc_snapshot.sv
// Two-level capture path: first buffer, then software-visible snapshot
// that stays locked until its high byte has been read.
module ptdcc_snapshot import ptdcc_pkg::*; #(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Capture side
  input wire logic [CNT_W-1:0] count_value,
  input wire logic capture,
  input wire logic update_cond,
  input wire logic release_lock,
  // Software side
  output logic [CNT_W-1:0] snap_value,
  output logic snap_locked
);

  typedef struct packed {
    logic [CNT_W-1:0] buf_val;
    logic pending;
    logic [CNT_W-1:0] snap;
    logic locked;
  } ptdcc_snap_t;

  ptdcc_snap_t r;
  ptdcc_snap_t next_r;
  logic load;

  always_comb begin
    next_r = r;
    if (capture) begin
      next_r.buf_val = count_value;
      next_r.pending = 1'b1;
    end
    load = r.pending & update_cond & ~r.locked;
    if (load) begin
      next_r.snap = r.buf_val;
      next_r.locked = 1'b1;
      next_r.pending = capture;
    end else if (release_lock) begin
      next_r.locked = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign snap_value = r.snap;
  assign snap_locked = r.locked;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  AST_CAPTURE_BUF: assert property (
    capture |=> r.buf_val == $past(count_value) && r.pending)
    else $error("capture did not store the counter");

  AST_UPDATE_LOAD: assert property (
    r.pending && update_cond && !r.locked
      |=> snap_value == $past(r.buf_val) && snap_locked)
    else $error("update did not move buffer to snapshot");

  AST_LOCK_HOLDS: assert property (
    snap_locked && !release_lock |=> $stable(snap_value) && snap_locked)
    else $error("locked snapshot changed");

  AST_NO_UPDATE_WO_COND: assert property (
    !update_cond |=> $stable(snap_value))
    else $error("snapshot changed without update");

endmodule // ptdcc_snapshot

// file: tb/testbench.sv
module testbench import ptdcc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;

  logic clk, reset_n, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [11:0] count_value;
  logic update_cond, debug_halted, trig_a_event, trig_b_event;
  logic timer_run, fault_out, trig_flag_a, trig_flag_b;
  logic match_set_a, match_clr_a, match_set_b, wave_a;
  logic [7:0] all_idx [13];
  logic [11:0] thr [3];
  int failures, total_checks;

  // One slave, so its ready is the bus ready
  assign hready = hreadyout;

  ptdcc_top #(.CNT_W(12)) i_ptdcc_top (
    .clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .count_value(count_value), .update_cond(update_cond),
    .debug_halted(debug_halted), .trig_a_event(trig_a_event),
    .trig_b_event(trig_b_event), .timer_run(timer_run),
    .fault_out(fault_out), .trig_flag_a(trig_flag_a),
    .trig_flag_b(trig_flag_b), .match_set_a(match_set_a),
    .match_clr_a(match_clr_a), .match_set_b(match_set_b), .wave_a(wave_a)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ------------------------------------------------------------
  // Report and checks
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: bit %b expected %b", $time, got, exp);
    end
  endtask

  // ------------------------------------------------------------
  // AHB-Lite master, entered right after a rising edge
  // ------------------------------------------------------------
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
    if (n >= 20) begin
      failures++;
      $display("CHECK FAILED at %0t: bus wait ran out", $time);
      stop_test();
    end
  endtask

  task automatic bus(input logic [7:0] idx, input logic wr,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= wr;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    wait_rdy();
    rd = hrdata;
    check1(hresp, 1'b0); // OKAY response
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    check32(rd, {24'h0, exp});
  endtask

  // Pulse an event, then an update condition
  task automatic capture(input logic a, input logic b, input logic upd);
    trig_a_event <= a;
    trig_b_event <= b;
    @(posedge clk);
    trig_a_event <= 1'b0;
    trig_b_event <= 1'b0;
    update_cond <= upd;
    @(posedge clk);
    update_cond <= 1'b0;
    @(posedge clk);
  endtask

  task automatic cmp_step(input logic [11:0] v, input logic [3:0] e);
    count_value <= v;
    @(posedge clk);
    @(negedge clk);
    check1(match_set_a, e[3]); // set A
    check1(match_clr_a, e[2]); // clear A
    check1(match_set_b, e[1]); // set B
    @(posedge clk);
    @(negedge clk);
    check1(wave_a, e[0]); // waveform
    @(posedge clk);
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    failures = 0;
    total_checks = 0;
    reset_n = 1'b0;
    {hsel, hwrite, update_cond, debug_halted} = 4'h0;
    {trig_a_event, trig_b_event} = 2'b00;
    htrans = 2'b00;
    haddr = 32'h0;
    hwdata = 32'h0;
    count_value = 12'h000;
    all_idx = '{IDX_DEBUG, IDX_SNAP_A_LO, IDX_SNAP_A_HI, IDX_SNAP_B_LO,
                IDX_SNAP_B_HI, IDX_SET_A_LO, IDX_SET_A_HI, IDX_CLR_A_LO,
                IDX_CLR_A_HI, IDX_SET_B_LO, IDX_SET_B_HI, IDX_STATUS,
                8'h3F};
    thr = '{12'h123, 12'h456, 12'h789};
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);

    foreach (all_idx[i]) rd_chk(all_idx[i], 8'h00); // reset zero
    $display("Test reset values done");

    for (int i = 0; i < 3; i++) begin
      bus(IDX_SET_A_LO + 8'(2 * i) + 8'h01, 1'b1, 8'hFF);
      rd_chk(IDX_SET_A_LO + 8'(2 * i) + 8'h01, 8'h0F); // high bits
      bus(IDX_SET_A_LO + 8'(2 * i), 1'b1, 8'hA5);
      rd_chk(IDX_SET_A_LO + 8'(2 * i), 8'hA5); // low byte
      bus(IDX_SET_A_LO + 8'(2 * i), 1'b1, thr[i][7:0]);
      bus(IDX_SET_A_LO + 8'(2 * i) + 8'h01, 1'b1, {4'h0, thr[i][11:8]});
    end
    bus(IDX_SNAP_A_LO, 1'b1, 8'h5A);
    rd_chk(IDX_SNAP_A_LO, 8'h00); // read-only
    bus(8'h3F, 1'b1, 8'h77);
    rd_chk(8'h3F, 8'h00); // unmapped
    $display("Test register access done");

    cmp_step(thr[0], 4'b1001);
    cmp_step(thr[1], 4'b0100);
    cmp_step(thr[2], 4'b0010);
    $display("Test compare done");

    count_value <= 12'h5A7;
    capture(1'b1, 1'b0, 1'b0);
    rd_chk(IDX_SNAP_A_LO, 8'h00); // buffered only
    capture(1'b0, 1'b0, 1'b1);
    rd_chk(IDX_STATUS, 8'h04); // lock A set
    rd_chk(IDX_SNAP_A_LO, 8'hA7);
    count_value <= 12'h111;
    capture(1'b1, 1'b0, 1'b1);
    rd_chk(IDX_SNAP_A_LO, 8'hA7); // held off
    rd_chk(IDX_SNAP_A_HI, 8'h05); // release
    capture(1'b0, 1'b0, 1'b1);
    rd_chk(IDX_SNAP_A_LO, 8'h11); // loads after release
    rd_chk(IDX_SNAP_A_HI, 8'h01);
    count_value <= 12'h2B3;
    bus(IDX_CAP_CMD, 1'b1, 8'h02);
    capture(1'b0, 1'b0, 1'b1);
    rd_chk(IDX_STATUS, 8'h08); // lock B set
    rd_chk(IDX_SNAP_B_LO, 8'hB3); // software capture
    rd_chk(IDX_SNAP_B_HI, 8'h02);
    count_value <= 12'h0C4;
    capture(1'b0, 1'b1, 1'b1);
    rd_chk(IDX_SNAP_B_LO, 8'hC4); // trigger B
    rd_chk(IDX_SNAP_B_HI, 8'h00);
    $display("Test capture done");

    debug_halted <= 1'b1;
    count_value <= 12'h0AA;
    @(negedge clk);
    check1(timer_run, 1'b0); // halted
    @(posedge clk);
    capture(1'b1, 1'b0, 1'b1);
    rd_chk(IDX_SNAP_A_LO, 8'h11); // event ignored
    count_value <= thr[0];
    repeat (2) @(posedge clk);
    @(negedge clk);
    check1(match_set_a, 1'b0); // no compare
    check1(fault_out, 1'b0); // no fault
    check1(trig_flag_a, 1'b0); // no flag
    @(posedge clk);
    bus(IDX_DEBUG, 1'b1, 8'h01);
    rd_chk(IDX_DEBUG, 8'h01); // run bit kept
    @(negedge clk);
    check1(timer_run, 1'b1); // keeps running
    @(posedge clk);
    bus(IDX_DEBUG, 1'b1, 8'h04);
    repeat (2) @(posedge clk);
    @(negedge clk);
    check1(fault_out, 1'b1); // fault raised
    check1(trig_flag_a, 1'b1); // flag A
    check1(trig_flag_b, 1'b1); // flag B
    @(posedge clk);
    rd_chk(IDX_STATUS, 8'h33); // halt, fault and both flags
    // Software capture is not an event, so it still works in halt
    bus(IDX_CAP_CMD, 1'b1, 8'h01);
    capture(1'b0, 1'b0, 1'b1);
    rd_chk(IDX_SNAP_A_LO, 8'h23); // software capture A
    rd_chk(IDX_SNAP_A_HI, 8'h01); // release
    debug_halted <= 1'b0;
    bus(IDX_DEBUG, 1'b1, 8'h00);
    bus(IDX_STATUS, 1'b1, 8'h30);
    @(negedge clk);
    check1(trig_flag_a, 1'b0); // flags clear
    check1(fault_out, 1'b0); // fault gone
    $display("Test debug halt done");
    stop_test();
  end
endmodule // testbench
